//--- logic/dls_door_lock_sequencer.sv
// Sequencer that drives the latch and dead bolt of a motor door cylinder.
`timescale 1ns/10ps
`default_nettype none
module dls_door_lock_sequencer
#(
  parameter int PRESCALE = dls_pkg::CLK_HZ
)
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output var  logic [31:0] o_wb_dat,
  output var  logic        o_wb_ack,
  // Field inputs.
  input  wire logic        i_knob_open,
  input  wire logic        i_switch,
  input  wire logic        i_door_open,
  input  wire logic        i_bolt_unlocked,
  input  wire logic        i_bolt_locked,
  input  wire logic        i_bolt_blocked,
  // Motor and relay outputs.
  output var  logic        o_bolt_unlock,
  output var  logic        o_bolt_lock,
  output var  logic        o_latch_retract,
  output var  logic        o_fault_22_20,
  output var  logic        o_fault_22_21,
  output var  logic        o_fault_led,
  output var  logic        o_open_17_19,
  output var  logic        o_open_17_18,
  output var  logic        o_irq
);
  import dls_pkg::*;

  localparam logic [SEC_W-1:0] HOLD_SEC  = SEC_W'(HOLD_LOCK_S);
  localparam logic [SEC_W-1:0] RETRY_SEC = SEC_W'(RETRY_WAIT_S);
  localparam logic [SEC_W-1:0] NOOP_SEC  = SEC_W'(NO_OPEN_WAIT_S);
  localparam logic [1:0]       ATT_MAX   = 2'(MAX_ATTEMPTS);

  dls_state_type    state_reg;
  dls_state_type    state_next;
  logic [31:0]      pre_reg;
  logic             tick;
  logic [SEC_W-1:0] sec_reg;
  logic [1:0]       att_reg;
  logic             night_unlock_reg;
  logic             was_locked_reg;
  logic             door_q_reg;
  logic             err_seen_open_reg;
  logic             dopen_reg;
  logic [1:0]       ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_ev;
  logic             night;
  logic             enable;
  logic             request;
  logic             door_rise;
  logic             door_fall;
  logic             wb_wr;

  assign night     = ctrl_reg[CTRL_NIGHT_BIT];
  assign enable    = ctrl_reg[CTRL_ENABLE_BIT];
  assign request   = i_knob_open | (i_switch & enable);
  assign door_rise = i_door_open & ~door_q_reg;
  assign door_fall = ~i_door_open & door_q_reg;
  // Writes land on the edge at which the master samples ack high.
  assign wb_wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

  // Seconds prescaler; restarts whenever the state changes.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_next != state_reg)
      pre_reg <= 32'h0;
    else if (pre_reg == 32'(PRESCALE - 1))
      pre_reg <= 32'h0;
    else
      pre_reg <= pre_reg + 32'h1;
  end
  assign tick = (pre_reg == 32'(PRESCALE - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_next != state_reg)
      sec_reg <= '0;
    else if (tick && sec_reg != '1)
      sec_reg <= sec_reg + SEC_W'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      door_q_reg <= 1'b0;
    else
      door_q_reg <= i_door_open;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (request)
          state_next = night ? ST_UNLOCK : ST_WAITOPN;
        else if (door_rise)
          state_next = ST_OPEN;
      ST_UNLOCK:
        if (i_bolt_unlocked)
          state_next = ST_WAITOPN;
      ST_WAITOPN:
        if (i_door_open)
          state_next = ST_OPEN;
        else if (sec_reg >= NOOP_SEC)
          state_next = (night_unlock_reg && was_locked_reg)
                       ? ST_LOCK : ST_IDLE;
      ST_OPEN:
        if (door_fall)
          state_next = night ? ST_HOLD : ST_IDLE;
      ST_HOLD:
        if (door_rise)
          state_next = ST_OPEN;
        else if (sec_reg >= HOLD_SEC)
          state_next = ST_LOCK;
      ST_LOCK:
        if (i_bolt_blocked)
          state_next = (att_reg == ATT_MAX - 2'h1)
                       ? ST_ERROR : ST_RETRY;
        else if (i_bolt_locked)
          state_next = ST_IDLE;
      ST_RETRY:
        if (sec_reg >= RETRY_SEC && i_bolt_unlocked)
          state_next = ST_LOCK;
      ST_ERROR:
        if (err_seen_open_reg && door_fall)
          state_next = night ? ST_HOLD : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Attempt counter resets on success or on leaving the error state.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      att_reg <= 2'h0;
    else if (state_reg == ST_LOCK && i_bolt_blocked)
      att_reg <= att_reg + 2'h1;
    else if (state_reg == ST_LOCK && i_bolt_locked)
      att_reg <= 2'h0;
    else if (state_reg == ST_ERROR && state_next != ST_ERROR)
      att_reg <= 2'h0;
  end

  // Remember the bolt position held before an opening command.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      night_unlock_reg <= 1'b0;
      was_locked_reg   <= 1'b0;
    end
    else if (state_reg == ST_IDLE && request)
    begin
      night_unlock_reg <= night;
      was_locked_reg   <= i_bolt_locked;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_reg != ST_ERROR)
      err_seen_open_reg <= 1'b0;
    else if (door_rise)
      err_seen_open_reg <= 1'b1;
  end

  // Motor commands; error drives the bolt back to unlocked, idle leaves it to manual operation.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_bolt_unlock   <= 1'b0;
      o_bolt_lock     <= 1'b0;
      o_latch_retract <= 1'b0;
    end
    else
    begin
      o_bolt_unlock   <= (state_next == ST_UNLOCK) ||
                         (state_next == ST_RETRY && !i_bolt_unlocked) ||
                         (state_next == ST_ERROR && !i_bolt_unlocked);
      o_bolt_lock     <= (state_next == ST_LOCK);
      o_latch_retract <= (state_next == ST_WAITOPN);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_fault_22_20 <= 1'b0;
      o_fault_22_21 <= 1'b0;
      o_fault_led   <= 1'b0;
    end
    else
    begin
      o_fault_22_20 <= (state_next == ST_ERROR);
      o_fault_22_21 <= (state_next != ST_ERROR);
      o_fault_led   <= (state_next == ST_ERROR);
    end
  end

  // Door-open indication is sticky until the contact closes.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      dopen_reg <= 1'b0;
    else if (i_door_open || state_next == ST_WAITOPN ||
             (state_reg == ST_UNLOCK && i_bolt_unlocked))
      dopen_reg <= 1'b1;
    else if (door_fall)
      dopen_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_open_17_19 <= 1'b0;
      o_open_17_18 <= 1'b0;
    end
    else
    begin
      o_open_17_19 <= dopen_reg;
      o_open_17_18 <= ~dopen_reg;
    end
  end

  assign irq_ev[IRQ_FAULT_BIT]   = (state_next == ST_ERROR) &&
                                   (state_reg != ST_ERROR);
  assign irq_ev[IRQ_OPENED_BIT]  = door_rise;
  assign irq_ev[IRQ_LOCKED_BIT]  = (state_reg == ST_LOCK) && i_bolt_locked &&
                                   !i_bolt_blocked;
  assign irq_ev[IRQ_BLOCKED_BIT] = (state_reg == ST_LOCK) && i_bolt_blocked;

  // Write one clears; a new event in the same cycle wins.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_stat_reg <= '0;
    else if (wb_wr && i_wb_adr == ADR_IRQ_STAT && i_wb_sel[0])
      irq_stat_reg <= (irq_stat_reg & ~i_wb_dat[IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_reg <= irq_stat_reg | irq_ev;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_reg     <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (wb_wr && i_wb_sel[0])
    begin
      if (i_wb_adr == ADR_CTRL)
        ctrl_reg <= i_wb_dat[1:0];
      if (i_wb_adr == ADR_IRQ_MASK)
        irq_mask_reg <= i_wb_dat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // Single-cycle acknowledge; unmapped addresses read zero.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else
    begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      case (i_wb_adr)
        ADR_CTRL:     o_wb_dat <= {30'h0, ctrl_reg};
        ADR_STATUS:   o_wb_dat <= {20'h0, att_reg, dopen_reg, i_door_open,
                                   state_reg};
        ADR_IRQ_STAT: o_wb_dat <= {28'h0, irq_stat_reg};
        ADR_IRQ_MASK: o_wb_dat <= {28'h0, irq_mask_reg};
        default:      o_wb_dat <= 32'h0;
      endcase
    end
  end
endmodule : dls_door_lock_sequencer
`default_nettype wire

//--- logic/dls_pkg.sv
// Package with constants for the door lock sequencer.
package dls_pkg;
  localparam int          CLK_HZ          = 250_000_000;
  localparam int          HOLD_LOCK_S     = 5;
  localparam int          RETRY_WAIT_S    = 10;
  localparam int          NO_OPEN_WAIT_S  = 15;
  localparam int          MAX_ATTEMPTS    = 3;
  localparam int          SEC_W           = 5;
  localparam logic [7:0]  ADR_CTRL        = 8'h00;
  localparam logic [7:0]  ADR_STATUS      = 8'h04;
  localparam logic [7:0]  ADR_IRQ_STAT    = 8'h08;
  localparam logic [7:0]  ADR_IRQ_MASK    = 8'h0C;
  localparam int          CTRL_NIGHT_BIT  = 0;
  localparam int          CTRL_ENABLE_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_FAULT_BIT   = 0;
  localparam int          IRQ_OPENED_BIT  = 1;
  localparam int          IRQ_LOCKED_BIT  = 2;
  localparam int          IRQ_BLOCKED_BIT = 3;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_UNLOCK  = 8'h02,
    ST_WAITOPN = 8'h04,
    ST_OPEN    = 8'h08,
    ST_HOLD    = 8'h10,
    ST_LOCK    = 8'h20,
    ST_RETRY   = 8'h40,
    ST_ERROR   = 8'h80
  } dls_state_type;
endpackage : dls_pkg

//--- verification/dls_checker_sva.sv
// Concurrent checks on the door lock sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module dls_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_door_open,
  input wire logic i_bolt_blocked,
  input wire logic o_bolt_unlock,
  input wire logic o_bolt_lock,
  input wire logic o_latch_retract,
  input wire logic o_fault_22_20,
  input wire logic o_fault_22_21,
  input wire logic o_fault_led,
  input wire logic o_open_17_19,
  input wire logic o_open_17_18,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_ack;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_fault_pair;
    !$past(i_sys_rst) |-> o_fault_22_20 != o_fault_22_21;
  endproperty
  a_fault_pair: assert property (p_fault_pair) else $error("fault pair");
  property p_fault_led;
    o_fault_led == o_fault_22_20;
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("fault lamp");
  property p_open_pair;
    !$past(i_sys_rst) |-> o_open_17_19 != o_open_17_18;
  endproperty
  a_open_pair: assert property (p_open_pair) else $error("open pair");
  property p_open_rise;
    $rose(i_door_open) |-> ##[1:3] o_open_17_19;
  endproperty
  a_open_rise: assert property (p_open_rise) else $error("open late");
  property p_open_hold;
    o_open_17_19 && i_door_open |=> o_open_17_19;
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open drop");
  property p_latch_rel;
    o_latch_retract && i_door_open |-> ##[1:4] !o_latch_retract;
  endproperty
  a_latch_rel: assert property (p_latch_rel) else $error("latch held");
  property p_blk_back;
    o_bolt_lock && i_bolt_blocked |-> ##[1:4] o_bolt_unlock;
  endproperty
  a_blk_back: assert property (p_blk_back) else $error("no return");
  property p_err_nolock;
    o_fault_22_20 && $past(o_fault_22_20) |-> !o_bolt_lock;
  endproperty
  a_err_nolock: assert property (p_err_nolock) else $error("err lock");
  property p_reset;
    disable iff (1'b0) i_sys_rst |=> !o_bolt_lock && !o_bolt_unlock &&
      !o_latch_retract && !o_irq && !o_fault_22_20;
  endproperty
  a_reset: assert property (p_reset) else $error("reset outs");
endmodule : dls_checker
bind dls_door_lock_sequencer dls_checker dls_checker_i (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_door_open(i_door_open),
  .i_bolt_blocked(i_bolt_blocked), .o_bolt_unlock(o_bolt_unlock),
  .o_bolt_lock(o_bolt_lock), .o_latch_retract(o_latch_retract),
  .o_fault_22_20(o_fault_22_20), .o_fault_22_21(o_fault_22_21),
  .o_fault_led(o_fault_led), .o_open_17_19(o_open_17_19),
  .o_open_17_18(o_open_17_18), .o_irq(o_irq));
`default_nettype wire

//--- verification/dls_motor_model.sv
// Behavioural bolt motor with end-position and blocking feedback.
`timescale 1ns/10ps
`default_nettype none
module dls_motor_model (
  input  wire logic i_clk,
  input  wire logic i_unlock,
  input  wire logic i_lock,
  input  wire logic i_jam,
  output var  logic o_unlocked = 1'b1,
  output var  logic o_locked = 1'b0,
  output var  logic o_blocked = 1'b0
);
  logic [1:0] run_reg = 2'h0;
  // The bolt needs four cycles of drive to reach an end position.
  always @(posedge i_clk)
  begin
    run_reg <= (i_lock || i_unlock) ? run_reg + 2'h1 : 2'h0;
    o_blocked <= i_lock && i_jam && (o_blocked || run_reg == 2'h3);
    if (i_lock)
      o_unlocked <= 1'b0;
    if (i_unlock)
      o_locked <= 1'b0;
    if (i_unlock && run_reg == 2'h3)
      o_unlocked <= 1'b1;
    if (i_lock && !i_jam && run_reg == 2'h3)
      o_locked <= 1'b1;
  end
endmodule : dls_motor_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the door lock sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dls_pkg::*;
  localparam int PS = 10;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat;
  logic ack, knob = 1'b0, sw = 1'b0, door = 1'b0, jam = 1'b0, lock_d = 1'b0;
  logic unl, lck, blk, m_unl, m_lck, latch, f20, f21, led, o19, o18, irq;
  int failures = 0, tests_run = 0, cnt = 0, locks = 0, n, base;
  wire [3:0] mon = {f20, m_lck, m_unl, latch};
  initial forever #2 clk = ~clk;
  dls_door_lock_sequencer #(.PRESCALE(PS)) dls_door_lock_sequencer_i (
    .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_knob_open(knob), .i_switch(sw),
    .i_door_open(door), .i_bolt_unlocked(unl), .i_bolt_locked(lck),
    .i_bolt_blocked(blk), .o_bolt_unlock(m_unl), .o_bolt_lock(m_lck),
    .o_latch_retract(latch), .o_fault_22_20(f20), .o_fault_22_21(f21),
    .o_fault_led(led), .o_open_17_19(o19), .o_open_17_18(o18), .o_irq(irq));
  dls_motor_model dls_motor_model_i (.i_clk(clk), .i_unlock(m_unl),
    .i_lock(m_lck), .i_jam(jam), .o_unlocked(unl), .o_locked(lck),
    .o_blocked(blk));
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    lock_d <= m_lck;
    if (m_lck && !lock_d)
      locks <= locks + 1;
    if (cnt == 20000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    chk("ack", 1, ack);
    dat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic waitb(input int b, input logic v, input int lim);
    n = 0;
    while (mon[b] !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : waitb
  task automatic drv(input logic k, s, d);
    knob <= k;
    sw <= s;
    door <= d;
    @(posedge clk);
  endtask : drv
  // Opens the door after the latch is pulled, then closes it again.
  task automatic pass_door();
    waitb(0, 1, 60);
    drv(0, 0, 1);
    waitb(0, 0, 40);
    drv(0, 0, 0);
  endtask : pass_door
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("relays", 32'hC, {f21, o18, f20, o19});
    wb(0, ADR_CTRL, 0);
    chk("ctrl", {30'h0, CTRL_RESET}, dat);
    wb(0, ADR_STATUS, 0);
    chk("state", 32'h1, {24'h0, dat[7:0]});
    wb(0, 8'h10, 0);
    chk("unmapped", 0, dat);
    wb(1, ADR_IRQ_MASK, 32'hF);
    $display("Test reset done");
    base = locks;
    drv(1, 0, 0);
    waitb(0, 1, 40);
    chk("day latch", 1, latch);
    drv(0, 0, 1);
    waitb(0, 0, 40);
    chk("latch back", 0, latch);
    chk("open out", 1, o19);
    drv(0, 0, 0);
    repeat (100) @(posedge clk);
    chk("day lock", base, locks);
    chk("open off", 0, o19);
    $display("Test day done");
    wb(1, ADR_CTRL, 32'h1);
    drv(1, 0, 0);
    waitb(0, 1, 60);
    chk("night unl", 1, unl);
    pass_door();
    waitb(2, 1, 200);
    chk("hold", 1, n >= 4 * PS && n <= 6 * PS + 4);
    waitb(2, 0, 40);
    chk("irq", 1, irq);
    wb(1, ADR_IRQ_MASK, 0);
    wb(0, ADR_IRQ_STAT, 0);
    chk("masked", 0, irq);
    chk("lock ev", 1, dat[IRQ_LOCKED_BIT]);
    wb(1, ADR_IRQ_MASK, 32'hF);
    wb(1, ADR_IRQ_STAT, 32'hF);
    wb(0, ADR_IRQ_STAT, 0);
    chk("cleared", 0, {dat[3:0], irq});
    $display("Test night done");
    wb(1, ADR_CTRL, 32'h3);
    drv(0, 1, 0);
    waitb(1, 1, 40);
    chk("sw unlock", 1, m_unl);
    drv(0, 0, 0);
    waitb(0, 1, 60);
    chk("sw unl", 1, unl);
    waitb(2, 1, 400);
    chk("no open", 1, n >= 14 * PS && n <= 16 * PS + 4);
    waitb(2, 0, 40);
    $display("Test switch done");
    jam <= 1'b1;
    base = locks;
    drv(1, 0, 0);
    pass_door();
    waitb(3, 1, 1000);
    chk("tries", base + 3, locks);
    chk("err relay", 32'h5, {f20, f21, led});
    repeat (150) @(posedge clk);
    chk("err unl", 1, unl);
    chk("no auto", base + 3, locks);
    wb(0, ADR_IRQ_STAT, 0);
    chk("fault ev", 1, dat[IRQ_FAULT_BIT]);
    drv(0, 0, 1);
    repeat (3) @(posedge clk);
    drv(0, 0, 0);
    waitb(3, 0, 20);
    chk("err clr", 0, f20);
    waitb(3, 1, 1000);
    chk("again", base + 6, locks);
    jam <= 1'b0;
    drv(0, 0, 1);
    repeat (3) @(posedge clk);
    drv(0, 0, 0);
    waitb(2, 1, 200);
    waitb(2, 0, 40);
    chk("recover", 2, {lck, f20});
    $display("Test error done");
    wb(1, ADR_CTRL, 32'h2);
    base = locks;
    drv(0, 1, 0);
    waitb(0, 1, 40);
    chk("day sw latch", 1, latch);
    chk("day sw bolt", 0, {m_unl, m_lck});
    drv(0, 0, 0);
    waitb(0, 0, 400);
    chk("day sw wait", 1, n >= 14 * PS && n <= 16 * PS + 4);
    chk("day sw lock", base, locks);
    $display("Test day switch done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
